// file: hw/bli_pkg.sv
package bli_pkg;
	// Bus address and direction
	localparam logic [6:0] BLI_SLAVE_ADDR = 7'h2C;
	localparam logic BLI_DIR_READ = 1'b1;
	localparam int BLI_BYTE_BITS = 8;
	// Register map of the device
	localparam logic [7:0] BLI_REG_BRIGHT = 8'h00;
	localparam logic [7:0] BLI_REG_CTRL = 8'h01;
	localparam logic [7:0] BLI_REG_STATUS = 8'h02;
	localparam logic [7:0] BLI_REG_CFG_LO = 8'hA0;
	localparam logic [7:0] BLI_REG_CFG_HI = 8'hAF;
	localparam logic [7:0] BLI_RST_BYTE = 8'h00;
	// Field positions
	localparam int BLI_CTRL_ON = 0;
	localparam int BLI_CTRL_MODE_LO = 1;
	localparam int BLI_STAT_OCP = 2;
	localparam int BLI_STAT_TSD = 1;
	// Host APB register offsets
	localparam logic [7:0] BLI_APB_CMD = 8'h00;
	localparam logic [7:0] BLI_APB_WDATA = 8'h04;
	localparam logic [7:0] BLI_APB_STATUS = 8'h08;
	localparam logic [7:0] BLI_APB_RDATA = 8'h0C;
	localparam logic [7:0] BLI_APB_DIV = 8'h10;
	// Command register fields
	localparam int BLI_CMD_START = 0;
	localparam int BLI_CMD_STOP = 1;
	localparam int BLI_CMD_WRITE = 2;
	localparam int BLI_CMD_READ = 3;
	localparam int BLI_CMD_NACK = 4;
	// Default bus clock phase length less one, in system clocks; a half period is two phases
	localparam logic [15:0] BLI_DIV_RESET = 16'h007D;
	typedef enum logic [2:0] {
		BLI_S_IDLE = 3'b000,
		BLI_S_ADDR = 3'b001,
		BLI_S_ACK = 3'b011,
		BLI_S_RX = 3'b010,
		BLI_S_TX = 3'b110,
		BLI_S_MACK = 3'b111
	} bli_slv_e;
endpackage : bli_pkg

// file: hw/bli_if.sv
`timescale 1ns/1ns
// Two wire link; open drain resolution done here
interface bli_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	wire scl = ~scl_oe;
	wire sda = ~(sda_m_oe | sda_s_oe);
	modport host (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
	modport dev (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : bli_if

// file: hw/bli_host.sv
`timescale 1ns/1ns
// Bus master end, driven by software over APB
module bli_host
	import bli_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	bli_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum logic [2:0] {H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b011,
		H_STOP = 3'b010, H_DONE = 3'b110} bli_hst_e;
	bli_hst_e st_q;
	logic [4:0] cmd_q; // Pending command bits
	logic [7:0] tx_q, rx_q; // Shift data
	logic [15:0] div_q, cnt_q; // Phase length divider
	logic [3:0] bit_q; // Bit index, 8 = ack slot
	logic [1:0] ph_q; // Phase in bit: 0 low,1 high,2 high late,3 low
	logic scl_low_q, sda_low_q, ack_q, busy_q;
	logic [2:0] sda_sy_q;
	logic sda_hold_q; // Last agreed data level
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire tick = (cnt_q == 16'h0000);
	wire sda_in = (sda_sy_q[2] == sda_sy_q[1]) ? sda_sy_q[1] : sda_hold_q; // Agreed data line
	wire go = wr & (paddr == BLI_APB_CMD) & ~busy_q;
	assign pready = 1'b1;
	assign pslverr = acc & ~(paddr inside {BLI_APB_CMD, BLI_APB_WDATA, BLI_APB_STATUS,
		BLI_APB_RDATA, BLI_APB_DIV});
	assign link.scl_o = 1'b0;
	assign link.scl_oe = scl_low_q;
	assign link.sda_m_o = 1'b0;
	assign link.sda_m_oe = sda_low_q;
	// Readback mux
	always_comb begin
		case (paddr)
			BLI_APB_STATUS: prdata = {30'h0000_0000, ack_q, busy_q};
			BLI_APB_RDATA: prdata = {24'h00_0000, rx_q};
			BLI_APB_DIV: prdata = {16'h0000, div_q};
			BLI_APB_WDATA: prdata = {24'h00_0000, tx_q};
			default: prdata = 32'h0000_0000;
		endcase
	end
	// Data line synchroniser; a change counts once the last two stages agree
	always_ff @(posedge clk) begin
		sda_sy_q <= rst ? 3'b111 : {sda_sy_q[1:0], link.sda};
		sda_hold_q <= rst ? 1'b1 : sda_in;
	end
	// Command sequencer; start, stop and each bit are master generated
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= H_IDLE;
			cmd_q <= 5'h00;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			div_q <= BLI_DIV_RESET;
			cnt_q <= 16'h0000;
			bit_q <= 4'h0;
			ph_q <= 2'h0;
			scl_low_q <= 1'b0;
			sda_low_q <= 1'b0;
			ack_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			if (wr & (paddr == BLI_APB_WDATA) & ~busy_q) tx_q <= pwdata[7:0];
			if (wr & (paddr == BLI_APB_DIV)) div_q <= pwdata[15:0];
			cnt_q <= tick ? div_q : cnt_q - 16'h0001;
			case (st_q)
				H_IDLE: begin
					if (go) begin
						cmd_q <= pwdata[4:0];
						busy_q <= 1'b1;
						ph_q <= 2'h0;
						st_q <= pwdata[BLI_CMD_START] ? H_START :
							(pwdata[BLI_CMD_WRITE] | pwdata[BLI_CMD_READ]) ? H_BIT :
							pwdata[BLI_CMD_STOP] ? H_STOP : H_DONE;
						bit_q <= 4'h0;
					end
				end
				H_START: if (tick) begin
					// Release data, raise clock, then pull data low while high
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: sda_low_q <= 1'b0;
						2'h1: scl_low_q <= 1'b0;
						2'h2: sda_low_q <= 1'b1;
						default: begin
							scl_low_q <= 1'b1;
							st_q <= (cmd_q[BLI_CMD_WRITE] | cmd_q[BLI_CMD_READ]) ? H_BIT :
								cmd_q[BLI_CMD_STOP] ? H_STOP : H_DONE;
						end
					endcase
				end
				H_BIT: if (tick) begin
					// Change data while low, sample while high
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: begin
							if (bit_q == 4'h8)
								sda_low_q <= cmd_q[BLI_CMD_READ] & ~cmd_q[BLI_CMD_NACK];
							else
								sda_low_q <= cmd_q[BLI_CMD_WRITE] & ~tx_q[3'h7 - bit_q[2:0]];
						end
						2'h1: scl_low_q <= 1'b0;
						2'h2: begin
							if (bit_q == 4'h8) ack_q <= ~sda_in;
							else rx_q <= {rx_q[6:0], sda_in};
						end
						default: begin
							scl_low_q <= 1'b1;
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h8) begin
								sda_low_q <= 1'b0;
								st_q <= cmd_q[BLI_CMD_STOP] ? H_STOP : H_DONE;
							end
						end
					endcase
				end
				H_STOP: if (tick) begin
					// Data low, clock high, then data rises while high
					ph_q <= ph_q + 2'h1;
					case (ph_q)
						2'h0: sda_low_q <= 1'b1;
						2'h1: scl_low_q <= 1'b0;
						2'h2: sda_low_q <= 1'b0;
						default: st_q <= H_DONE;
					endcase
				end
				H_DONE: begin
					busy_q <= 1'b0;
					st_q <= H_IDLE;
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end
endmodule : bli_host

// file: hw/bli_dev.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
// Contract
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Sample high, SDA change while high aborts
// - Bytes eight bits, MSB first, then ack
// - Ninth pulse; receiver holds SDA low
// - Respond to address 2Ch only
// - Seven address bits, eighth is direction
// - Acknowledge only on address match
// - Write: register address, data, stored
// - Further write bytes go to address+1
// - Read after repeated start drives register
// - Master ack increments address, next byte
// - Master nack then stop; slave releases
// - Master owns start/stop; busy until stop
// - Repeated start allowed mid transaction
// - Overcurrent disables boost, sets bit, restarts
// - Thermal cutoff disables LEDs and boost
// - Fault bits sticky until status read
// - Enable input low holds shutdown
// - Mode selects on bit or PWM activity
// - Configuration writes blocked while active
// - Fault bits live in status 02h
module bli_dev
	import bli_pkg::*;
#(
	parameter int CFG_WORDS = 16 // Configuration bytes held
)
(
	input wire logic clk,
	input wire logic rst,
	bli_if.dev link,
	input wire logic chip_enable_io_supply,
	input wire logic boost_overcurrent_guard,
	input wire logic thermal_cutoff,
	input wire logic pwm_in,
	output logic boost_en,
	output logic led_en,
	output logic active,
	output logic [7:0] brightness
);
	// The index into the configuration bytes is four bits wide
	if (CFG_WORDS < 1 || CFG_WORDS > 16) begin : g_bad_cfg
		$error("CFG_WORDS out of range");
	end
	bli_slv_e st_q;
	logic [2:0] scl_sy_q, sda_sy_q, en_sy_q, ocp_sy_q, tsd_sy_q, pwm_sy_q;
	logic scl_q, sda_q; // Last agreed line levels
	logic en_q, ocp_q, tsd_q, pwm_q; // Last agreed pin levels
	logic byte_is_ptr_q; // Byte just acked was the pointer
	logic [7:0] sh_q; // Receive shift
	logic [7:0] tx_q; // Transmit shift
	logic [3:0] cnt_q; // Bits received in this byte
	logic [7:0] ptr_q; // Register pointer
	logic ptr_ok_q; // Pointer byte already taken
	logic rd_q; // Current transfer reads
	logic ack_low_q; // Slave pulls SDA
	logic [7:0] bright_q, ctrl_q;
	logic ocp_st_q, tsd_st_q; // Sticky fault bits
	logic pwm_seen_q;
	logic [7:0] cfg_q [CFG_WORDS];
	// Agreed levels from three stage synchronisers
	wire scl_n = (scl_sy_q[2] == scl_sy_q[1]) ? scl_sy_q[1] : scl_q;
	wire sda_n = (sda_sy_q[2] == sda_sy_q[1]) ? sda_sy_q[1] : sda_q;
	// A pin change counts only once two stages agree; a one-flop glitch is ignored
	wire en_n = (en_sy_q[2] == en_sy_q[1]) ? en_sy_q[1] : en_q;
	wire ocp_n = (ocp_sy_q[2] == ocp_sy_q[1]) ? ocp_sy_q[1] : ocp_q;
	wire tsd_n = (tsd_sy_q[2] == tsd_sy_q[1]) ? tsd_sy_q[1] : tsd_q;
	wire pwm_n = (pwm_sy_q[2] == pwm_sy_q[1]) ? pwm_sy_q[1] : pwm_q;
	wire scl_rise = scl_n & ~scl_q;
	wire scl_fall = ~scl_n & scl_q;
	wire start_ev = scl_q & scl_n & sda_q & ~sda_n;
	wire stop_ev = scl_q & scl_n & ~sda_q & sda_n;
	wire [7:0] byte_in = {sh_q[6:0], sda_n};
	wire addr_hit = (byte_in[7:1] == BLI_SLAVE_ADDR);
	wire is_cfg = (ptr_q >= BLI_REG_CFG_LO) & (ptr_q < BLI_REG_CFG_LO + 8'(CFG_WORDS));
	wire [3:0] cfg_idx = 4'(ptr_q - BLI_REG_CFG_LO);
	wire [7:0] status_v = (8'(ocp_st_q) << BLI_STAT_OCP) | (8'(tsd_st_q) << BLI_STAT_TSD);
	wire pwm_on = pwm_seen_q;
	wire bl_req = (ctrl_q[BLI_CTRL_MODE_LO +: 2] == 2'b00) ? pwm_on : ctrl_q[BLI_CTRL_ON];
	wire [7:0] rd_mux = (ptr_q == BLI_REG_BRIGHT) ? bright_q :
		(ptr_q == BLI_REG_CTRL) ? ctrl_q :
		(ptr_q == BLI_REG_STATUS) ? status_v :
		is_cfg ? cfg_q[cfg_idx] : BLI_RST_BYTE;
	// Byte complete on the eighth rising clock
	wire byte_done = scl_rise & (cnt_q == 4'h7) & (st_q inside {BLI_S_ADDR, BLI_S_RX});
	wire wr_strobe = byte_done & (st_q == BLI_S_RX) & ptr_ok_q;
	wire stat_read = scl_fall & (st_q == BLI_S_TX) & (cnt_q == 4'h0) & (ptr_q == BLI_REG_STATUS);
	// Mid-bit change on data while clock high, outside start/stop
	// Own drive and transmit bits excluded, as those edges are ours
	wire abort_ev = scl_q & scl_n & (sda_n != sda_q) & ~ack_low_q & (st_q != BLI_S_TX)
		& (st_q != BLI_S_IDLE);
	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe = ack_low_q;
	assign active = en_n & bl_req;
	assign boost_en = active & ~ocp_n & ~tsd_n;
	assign led_en = active & ~tsd_n;
	assign brightness = bright_q;
	// Input synchronisers; only the last two stages feed logic
	always_ff @(posedge clk) begin
		scl_sy_q <= rst ? 3'b111 : {scl_sy_q[1:0], link.scl};
		sda_sy_q <= rst ? 3'b111 : {sda_sy_q[1:0], link.sda};
		en_sy_q <= rst ? 3'b000 : {en_sy_q[1:0], chip_enable_io_supply};
		ocp_sy_q <= rst ? 3'b000 : {ocp_sy_q[1:0], boost_overcurrent_guard};
		tsd_sy_q <= rst ? 3'b000 : {tsd_sy_q[1:0], thermal_cutoff};
		pwm_sy_q <= rst ? 3'b000 : {pwm_sy_q[1:0], pwm_in};
		scl_q <= rst ? 1'b1 : scl_n;
		sda_q <= rst ? 1'b1 : sda_n;
		en_q <= rst ? 1'b0 : en_n;
		ocp_q <= rst ? 1'b0 : ocp_n;
		tsd_q <= rst ? 1'b0 : tsd_n;
		pwm_q <= rst ? 1'b0 : pwm_n;
	end
	// Sticky faults; a new fault wins over the clearing read
	always_ff @(posedge clk) begin
		if (rst | ~en_n) begin
			ocp_st_q <= 1'b0;
			tsd_st_q <= 1'b0;
			pwm_seen_q <= 1'b0;
		end else begin
			ocp_st_q <= ocp_n | (ocp_st_q & ~stat_read);
			tsd_st_q <= tsd_n | (tsd_st_q & ~stat_read);
			pwm_seen_q <= pwm_seen_q | pwm_n;
		end
	end
	// Register writes; shutdown clears brightness and control
	always_ff @(posedge clk) begin
		if (rst | ~en_n) begin
			bright_q <= BLI_RST_BYTE;
			ctrl_q <= BLI_RST_BYTE;
		end else if (wr_strobe) begin
			if (ptr_q == BLI_REG_BRIGHT) bright_q <= byte_in;
			if (ptr_q == BLI_REG_CTRL) ctrl_q <= byte_in;
		end
	end
	// Configuration bytes, locked while active
	for (genvar i = 0; i < CFG_WORDS; i++) begin : g_cfg
		always_ff @(posedge clk) begin
			if (rst) cfg_q[i] <= BLI_RST_BYTE;
			else if (wr_strobe & is_cfg & (cfg_idx == 4'(i)) & ~active) cfg_q[i] <= byte_in;
		end
	end
	// Protocol engine
	always_ff @(posedge clk) begin
		if (rst | ~en_n) begin
			st_q <= BLI_S_IDLE;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			cnt_q <= 4'h0;
			ptr_q <= 8'h00;
			ptr_ok_q <= 1'b0;
			rd_q <= 1'b0;
			ack_low_q <= 1'b0;
		end else if (start_ev) begin
			// Start or repeated start; pointer kept
			st_q <= BLI_S_ADDR;
			cnt_q <= 4'h0;
			ack_low_q <= 1'b0;
		end else if (stop_ev | abort_ev) begin
			st_q <= BLI_S_IDLE;
			ack_low_q <= 1'b0;
		end else begin
			if (scl_rise & (st_q inside {BLI_S_ADDR, BLI_S_RX})) begin
				sh_q <= byte_in;
				cnt_q <= cnt_q + 4'h1;
			end
			case (st_q)
				BLI_S_ADDR: if (byte_done) begin
					if (addr_hit) begin
						rd_q <= (byte_in[0] == BLI_DIR_READ);
						st_q <= BLI_S_ACK;
					end else begin
						st_q <= BLI_S_IDLE;
					end
				end
				BLI_S_RX: if (byte_done) begin
					st_q <= BLI_S_ACK;
					if (ptr_ok_q) ptr_q <= ptr_q; // Increment after ack
				end
				BLI_S_ACK: begin
					// Pull low on first low phase; after ninth pulse release, or drive the first read bit
					if (scl_fall & ~ack_low_q) ack_low_q <= 1'b1;
					else if (scl_fall & ack_low_q) begin
						cnt_q <= 4'h0;
						sh_q <= 8'h00;
						if (rd_q) begin
							st_q <= BLI_S_TX;
							tx_q <= {rd_mux[6:0], 1'b0};
							ack_low_q <= ~rd_mux[7];
						end else begin
							ack_low_q <= 1'b0;
							st_q <= BLI_S_RX;
							if (ptr_ok_q & (cnt_q == 4'h8)) ptr_q <= ptr_q + 8'h01;
						end
					end
				end
				BLI_S_TX: if (scl_fall) begin
					// Shift out MSB first; release for master ack
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'h7) begin
						// Ack slot entered now so the ninth rise is the one sampled
						ack_low_q <= 1'b0;
						st_q <= BLI_S_MACK;
					end else begin
						ack_low_q <= ~tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
					end
				end
				BLI_S_MACK: if (scl_rise) begin
					if (sda_n) st_q <= BLI_S_IDLE;
					else begin
						ptr_q <= ptr_q + 8'h01;
						cnt_q <= 4'h0;
						st_q <= BLI_S_RX;
						rd_q <= 1'b1;
					end
				end
				default: ;
			endcase
			// Next read byte loaded on falling edge after master ack
			if (st_q == BLI_S_RX & rd_q & scl_fall) begin
				st_q <= BLI_S_TX;
				cnt_q <= 4'h0;
				tx_q <= {rd_mux[6:0], 1'b0};
				ack_low_q <= ~rd_mux[7];
			end
			// First data byte after the address byte is the pointer
			if (st_q == BLI_S_ACK & scl_fall & ack_low_q & ~rd_q) begin
				if (~ptr_ok_q & byte_is_ptr_q) begin
					ptr_q <= sh_q;
					ptr_ok_q <= 1'b1;
				end
			end
			// A fresh write addressing expects a new pointer byte
			if (st_q == BLI_S_ADDR & byte_done & addr_hit & ~byte_in[0]) ptr_ok_q <= 1'b0;
		end
	end
	// Marks that the byte just acked was a pointer, not the address
	always_ff @(posedge clk) begin
		if (rst | start_ev) byte_is_ptr_q <= 1'b0;
		else if (byte_done & st_q == BLI_S_RX) byte_is_ptr_q <= ~ptr_ok_q;
		else if (byte_done) byte_is_ptr_q <= 1'b0;
	end
endmodule : bli_dev

// file: testbench/bli_chk.sv
`timescale 1ns/1ns
// Link watcher; sees the resolved wires and the device pull only
module bli_chk
	import bli_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q; // Line levels one clock back
	logic sda_q;
	logic [3:0] cnt_q; // Clock rises within the byte
	logic [7:0] sh_q; // Bits seen, newest at bit 0
	logic [1:0] idx_q; // Byte number, 3 while idle
	logic wr_q; // Addressed for write
	logic rd_q; // Addressed for read
	wire start_w = scl && scl_q && sda_q && !sda;
	wire stop_w = scl && scl_q && !sda_q && sda;
	wire rise_w = scl && !scl_q;
	wire ninth_w = rise_w && (cnt_q == 4'h8);
	wire match_w = (sh_q[7:1] == BLI_SLAVE_ADDR);
	// Frame tracker; the rise before a start or stop wraps the count to 1
	always_ff @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (rst || stop_w) begin
			cnt_q <= 4'h1;
			idx_q <= 2'h3;
		end else if (start_w) begin
			cnt_q <= 4'h0;
			idx_q <= 2'h0;
		end else if (rise_w) begin
			cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
			sh_q <= {sh_q[6:0], sda};
			if (ninth_w && idx_q < 2'h2) begin
				idx_q <= idx_q + 2'h1;
			end
		end
	end
	// Direction caught at the address acknowledge
	always_ff @(posedge clk) begin
		if (rst || stop_w || start_w) begin
			wr_q <= 1'h0;
			rd_q <= 1'h0;
		end else if (ninth_w && idx_q == 2'h0) begin
			wr_q <= match_w && !sh_q[0];
			rd_q <= match_w && sh_q[0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_addr_ack;
		ninth_w && idx_q == 2'h0;
	endsequence
	property p_addr_ack;
		s_addr_ack |-> sda_s_oe == match_w;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
	property p_ptr_ack;
		ninth_w && idx_q == 2'h1 && wr_q |-> sda_s_oe;
	endproperty
	a_ptr_ack: assert property (p_ptr_ack) else $error("pointer byte not acknowledged");
	property p_rd_rel;
		ninth_w && rd_q |-> !sda_s_oe;
	endproperty
	a_rd_rel: assert property (p_rd_rel) else $error("data held in master ack slot");
	property p_no_start;
		scl && scl_q |-> !$rose(sda_s_oe);
	endproperty
	a_no_start: assert property (p_no_start) else $error("device pulled data in clock high");
	property p_no_stop;
		scl && scl_q |-> !$fell(sda_s_oe);
	endproperty
	a_no_stop: assert property (p_no_stop) else $error("device let data go in clock high");
	property p_stop_idle;
		stop_w |=> !sda_s_oe [*8];
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("data driven after stop");
	property p_rst_rel;
		$fell(rst) |-> !sda_s_oe [*2];
	endproperty
	a_rst_rel: assert property (p_rst_rel) else $error("data driven out of reset");
	property p_frame;
		start_w || stop_w |-> cnt_q == 4'h1;
	endproperty
	a_frame: assert property (p_frame) else $error("byte not nine pulses long");
endmodule : bli_chk

// file: testbench/backlight_i2c_slave_faults_bench.sv
`timescale 1ns/1ns
// Host and device joined on one link; software side over APB
module backlight_i2c_slave_faults_bench
	import bli_pkg::*;
;
	localparam logic [4:0] C_STA = 5'h01 << BLI_CMD_START; // Command words
	localparam logic [4:0] C_STO = 5'h01 << BLI_CMD_STOP;
	localparam logic [4:0] C_WR = 5'h01 << BLI_CMD_WRITE;
	localparam logic [4:0] C_RD = 5'h01 << BLI_CMD_READ;
	localparam logic [4:0] C_NAK = 5'h01 << BLI_CMD_NACK;
	localparam logic [7:0] ADDR_W = {BLI_SLAVE_ADDR, 1'h0}; // First byte, write
	localparam logic [7:0] ADDR_R = {BLI_SLAVE_ADDR, BLI_DIR_READ};
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err_q;
	logic [7:0] paddr, brightness;
	logic [31:0] pwdata, prdata;
	logic chip_enable_io_supply, boost_overcurrent_guard, thermal_cutoff, pwm_in;
	logic boost_en, led_en, active;
	int n_mismatch, n_checks;
	bli_if link();
	bli_host i_bli_host(.clk(clk), .rst(rst), .link(link), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	bli_dev #(.CFG_WORDS(16)) i_bli_dev(.clk(clk), .rst(rst), .link(link),
		.chip_enable_io_supply(chip_enable_io_supply),
		.boost_overcurrent_guard(boost_overcurrent_guard), .thermal_cutoff(thermal_cutoff),
		.pwm_in(pwm_in), .boost_en(boost_en), .led_en(led_en), .active(active),
		.brightness(brightness));
	bli_chk i_bli_chk(.clk(clk), .rst(rst), .sda_s_oe(link.sda_s_oe), .scl(link.scl),
		.sda(link.sda));
	// Verdict and end of run
	task automatic report_and_stop;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	// Count a comparison, report a miss at once
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// A bounded wait ran out
	task automatic hang;
		n_mismatch++;
		report_and_stop();
	endtask : hang
	// One APB transfer; request held until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) hang();
		q = prdata;
		err_q = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge so the next setup never lands in this time step
		@(posedge clk);
	endtask : apb
	// Byte level command; busy polled with a bound
	task automatic cmd(input logic [4:0] c, input logic [7:0] wd, output logic [7:0] rd,
		output logic ack);
		logic [31:0] q;
		int n;
		apb(1'h1, BLI_APB_WDATA, {24'h00_0000, wd}, q);
		apb(1'h1, BLI_APB_CMD, {27'h000_0000, c}, q);
		n = 0;
		do begin
			apb(1'h0, BLI_APB_STATUS, 32'h0000_0000, q);
			n++;
		end while (q[0] !== 1'h0 && n < 500);
		if (n >= 500) hang();
		ack = q[1];
		apb(1'h0, BLI_APB_RDATA, 32'h0000_0000, q);
		rd = q[7:0];
	endtask : cmd
	// Start or stop on the link
	task automatic ctl(input logic [4:0] c);
		logic [7:0] r;
		logic a;
		cmd(c, 8'h00, r, a);
	endtask : ctl
	// Byte out, acknowledge compared
	task automatic put(input logic [7:0] b, input logic exp);
		logic [7:0] r;
		logic a;
		cmd(C_WR, b, r, a);
		chk({31'h0, a}, {31'h0, exp});
	endtask : put
	// Byte in, compared; the last one is not acknowledged
	task automatic get(input logic last, input logic [7:0] exp);
		logic [7:0] r;
		logic a;
		cmd(last ? (C_RD | C_NAK) : C_RD, 8'h00, r, a);
		chk({24'h00_0000, r}, {24'h00_0000, exp});
	endtask : get
	// Register write of one or two bytes, then settle
	task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1,
		input logic two);
		ctl(C_STA);
		put(ADDR_W, 1'h1);
		put(p, 1'h1);
		put(d0, 1'h1);
		if (two) put(d1, 1'h1);
		ctl(C_STO);
		repeat (8) @(posedge clk);
	endtask : wr
	// Pointer write, repeated start, read address
	task automatic rd_open(input logic [7:0] p);
		ctl(C_STA);
		put(ADDR_W, 1'h1);
		put(p, 1'h1);
		ctl(C_STA);
		put(ADDR_R, 1'h1);
	endtask : rd_open
	// Divider reset value, shorter bit time, unmapped offset
	task automatic t_apb;
		logic [31:0] q;
		apb(1'h0, BLI_APB_DIV, 32'h0000_0000, q);
		chk(q, {16'h0000, BLI_DIV_RESET});
		apb(1'h1, BLI_APB_DIV, 32'h0000_0009, q);
		apb(1'h0, BLI_APB_DIV, 32'h0000_0000, q);
		chk(q, 32'h0000_0009);
		apb(1'h0, 8'h40, 32'h0000_0000, q);
		chk({31'h0, err_q}, 32'h1);
	endtask : t_apb
	// Foreign addresses in both directions stay unanswered
	task automatic t_foreign;
		ctl(C_STA);
		put({BLI_SLAVE_ADDR ^ 7'h01, 1'h0}, 1'h0);
		ctl(C_STO);
		ctl(C_STA);
		put({BLI_SLAVE_ADDR ^ 7'h40, BLI_DIR_READ}, 1'h0);
		ctl(C_STO);
	endtask : t_foreign
	// Incrementing write turns the backlight on; incrementing read back
	task automatic t_wr_rd;
		wr(BLI_REG_BRIGHT, 8'hA5, 8'h05, 1'h1);
		chk({24'h00_0000, brightness}, 32'h0000_00A5);
		chk({29'h0, active, led_en, boost_en}, 32'h7);
		rd_open(BLI_REG_BRIGHT);
		get(1'h0, 8'hA5);
		get(1'h1, 8'h05);
		ctl(C_STO);
	endtask : t_wr_rd
	// Fault shutdown, restart, status sticky until read
	task automatic t_faults;
		boost_overcurrent_guard <= 1'h1;
		repeat (8) @(posedge clk);
		chk({30'h0, led_en, boost_en}, 32'h2);
		boost_overcurrent_guard <= 1'h0;
		thermal_cutoff <= 1'h1;
		repeat (8) @(posedge clk);
		chk({30'h0, led_en, boost_en}, 32'h0);
		thermal_cutoff <= 1'h0;
		repeat (8) @(posedge clk);
		chk({30'h0, led_en, boost_en}, 32'h3);
		rd_open(BLI_REG_STATUS);
		// Overcurrent at bit 2, thermal at bit 1
		get(1'h1, 8'h06);
		ctl(C_STO);
		rd_open(BLI_REG_STATUS);
		get(1'h1, 8'h00);
		ctl(C_STO);
	endtask : t_faults
	// Configuration locked while active; PWM mode; shutdown clears
	task automatic t_lock;
		wr(BLI_REG_CFG_LO, 8'h3C, 8'h00, 1'h0);
		rd_open(BLI_REG_CFG_LO);
		get(1'h1, BLI_RST_BYTE);
		ctl(C_STO);
		wr(BLI_REG_CTRL, 8'h00, 8'h00, 1'h0);
		chk({31'h0, active}, 32'h0);
		wr(BLI_REG_CFG_LO, 8'h3C, 8'h00, 1'h0);
		rd_open(BLI_REG_CFG_LO);
		get(1'h1, 8'h3C);
		ctl(C_STO);
		pwm_in <= 1'h1;
		repeat (8) @(posedge clk);
		chk({31'h0, active}, 32'h1);
		chip_enable_io_supply <= 1'h0;
		repeat (8) @(posedge clk);
		chk({23'h0, active, brightness}, 32'h0);
		chip_enable_io_supply <= 1'h1;
	endtask : t_lock
	// Free running system clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// Reset, then the scenarios in turn
	initial begin
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		chip_enable_io_supply = 1'h1;
		boost_overcurrent_guard = 1'h0;
		thermal_cutoff = 1'h0;
		pwm_in = 1'h0;
		n_mismatch = 0;
		n_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		// Let the device input synchronisers fill
		repeat (4) @(posedge clk);
		t_apb();
		t_foreign();
		t_wr_rd();
		t_faults();
		t_lock();
		report_and_stop();
	end
endmodule : backlight_i2c_slave_faults_bench
